// File: fcp_pkg.sv
package fcp_pkg;
    // clock
    localparam int unsigned CLK_PERIOD_NS = 10;
    // register indices, byte address is four times the index
    localparam logic [15:0] IDX_ADDR_TOP = 16'hA012;
    localparam logic [15:0] IDX_INTP_LO = 16'hA013;
    localparam logic [15:0] IDX_INTP_HI = 16'hA014;
    localparam logic [15:0] IDX_LOW_BOUND = 16'hA025;
    localparam logic [15:0] IDX_HIGH_BOUND = 16'hA026;
    localparam logic [15:0] IDX_GUARD = 16'hA030;
    localparam logic [15:0] IDX_IRQ_STAT = 16'hA031;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hA032;
    localparam int unsigned PADDR_W = 18;
    // reset values
    localparam logic RST_ADDR_TOP = 1'b0;
    localparam logic [7:0] RST_LOW_BOUND = 8'hFF;
    localparam logic [7:0] RST_HIGH_BOUND = 8'h00;
    localparam logic [7:0] RST_INTP = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // field positions
    localparam int unsigned ADDR_TOP_BIT = 0;
    localparam int unsigned UPD_EN_BIT = 7;
    localparam int unsigned UNIT_LSB = 9;
    localparam int unsigned SEG_LSB = 13;
    localparam int unsigned RANGE_BITS = 15;
    localparam logic [7:0] UPD_EN_VALUE = 8'h80;
    localparam int unsigned IRQ_CMD_FAIL = 0;
    localparam int unsigned IRQ_RD_ZERO = 1;
    // timed write guard
    localparam logic [7:0] GUARD_KEY = 8'hA5;
    localparam int unsigned GUARD_WIN_NS = 160;
    localparam int unsigned GUARD_WIN_CYC = GUARD_WIN_NS / CLK_PERIOD_NS;
    localparam int unsigned GUARD_CNT_W = 5;

    typedef enum logic [1:0] {
        FCP_CMD_READ,
        FCP_CMD_ERASE,
        FCP_CMD_WRITE,
        FCP_CMD_OTHER
    } fcp_cmd_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [PADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } fcp_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fcp_apb_rsp_s;

    typedef struct packed {
        logic valid;
        fcp_cmd_e kind;
        logic [15:0] addr;
    } fcp_cmd_req_s;

    typedef struct packed {
        logic go;
        logic fail;
        logic [16:0] addr;
    } fcp_cmd_rsp_s;

    typedef struct packed {
        logic valid;
        logic [16:0] addr;
        logic [7:0] data;
    } fcp_rd_s;
endpackage

// File: fcp_top.sv
`timescale 1ns/1ps
// Function
// - bit 0 of the address top register supplies flash address bit 16
// - an erase or write command aimed into a protection zone is not run and reports failure
// - low zone from array bottom, high zone up to array top
// - low bound counts 512-byte units, protects units 0 to value minus one
// - low bound resets to all ones
// - high bound counts 512-byte units, protects value plus one to top unit
// - high bound resets to zero
// - internally protected addresses read as zero for table and byte reads
// - both internal protection registers clear to zero on every reset
// - internal protection bits can only be set by writes
// - update enable set by writing only bit 7; ranges accepted only while set
// - setting any range bit clears update enable until reset
// - fifteen range bits, 8 KB apart up to top; lowest set bit wins
// - internal read protection inactive after reset
// - internal protection writes gated by the timed write guard
// - zone check applies to erase and write commands, failure bit set
module fcp_top
    import fcp_pkg::*;
(
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    // register bus
    input wire fcp_pkg::fcp_apb_req_s I_APB,
    output fcp_pkg::fcp_apb_rsp_s O_APB,
    // flash commands
    input wire fcp_pkg::fcp_cmd_req_s I_CMD,
    output fcp_pkg::fcp_cmd_rsp_s O_CMD,
    // program and byte reads from the array
    input wire fcp_pkg::fcp_rd_s I_RD,
    output fcp_pkg::fcp_rd_s O_RD,
    // interrupt
    output logic O_IRQ
);
    import fcp_pkg::*;

    typedef struct packed {
        logic addr_top;
        logic [7:0] low_bound;
        logic [7:0] high_bound;
        logic [7:0] prot_lo;
        logic [6:0] prot_hi;
        logic upd_en;
        logic guard_open;
        logic [GUARD_CNT_W-1:0] guard_cnt;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
        fcp_apb_rsp_s apb;
        fcp_cmd_rsp_s cmd;
        fcp_rd_s rd;
    } fcp_state_s;

    localparam fcp_state_s ST_RST = '{
        addr_top: RST_ADDR_TOP,
        low_bound: RST_LOW_BOUND,
        high_bound: RST_HIGH_BOUND,
        prot_lo: RST_INTP,
        prot_hi: RST_INTP[6:0],
        upd_en: RST_INTP[UPD_EN_BIT],
        guard_open: 1'b0,
        guard_cnt: '0,
        irq_stat: RST_IRQ,
        irq_mask: RST_IRQ,
        irq: 1'b0,
        apb: '0,
        cmd: '0,
        rd: '0
    };

    fcp_state_s st_q;
    fcp_state_s st_d;

    // internal protection hit, one comparator per range bit
    logic [RANGE_BITS-1:0] range_bits;
    logic [RANGE_BITS-1:0] seg_hit;
    logic rd_prot;

    assign range_bits = {st_q.prot_hi, st_q.prot_lo};

    // an address at or above bit k's start is covered; the lowest set bit
    // therefore always yields the widest region, which is its priority
    for (genvar k = 0; k < RANGE_BITS; k++) begin : g_seg
        assign seg_hit[k] = range_bits[k] && (I_RD.addr[16:SEG_LSB] > 4'(k));
    end
    assign rd_prot = |seg_hit;

    // zone check on the full command address
    logic [16:0] cmd_full;
    logic [7:0] cmd_unit;
    logic cmd_guarded;
    logic zone_hit;

    assign cmd_full = {st_q.addr_top, I_CMD.addr};
    assign cmd_unit = cmd_full[16:UNIT_LSB];
    assign cmd_guarded = (I_CMD.kind == FCP_CMD_ERASE) || (I_CMD.kind == FCP_CMD_WRITE);
    assign zone_hit = (cmd_unit < st_q.low_bound) || (cmd_unit > st_q.high_bound);

    // bus decode
    logic [15:0] idx;
    logic setup;
    logic wr;
    logic mapped;
    logic [7:0] wdat;

    assign idx = I_APB.paddr[PADDR_W-1:2];
    assign setup = I_APB.psel && !I_APB.penable;
    assign wr = I_APB.psel && I_APB.penable && I_APB.pwrite && st_q.apb.pready;
    assign wdat = I_APB.pwdata[7:0];
    assign mapped = (I_APB.paddr[1:0] == 2'b00) &&
        (idx == IDX_ADDR_TOP || idx == IDX_INTP_LO || idx == IDX_INTP_HI ||
         idx == IDX_LOW_BOUND || idx == IDX_HIGH_BOUND || idx == IDX_GUARD ||
         idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK);

    always_comb begin
        logic [7:0] rdat;
        logic locked;
        logic [1:0] ev;
        logic [1:0] clr;
        rdat = 8'h00;
        locked = |range_bits;
        ev = 2'b00;
        clr = 2'b00;
        st_d = st_q;

        // bus answer is prepared in the setup cycle so pready and prdata come from flops
        st_d.apb.pready = setup;
        st_d.apb.pslverr = setup && !mapped;
        unique case (idx)
            IDX_ADDR_TOP: rdat = {7'h00, st_q.addr_top};
            IDX_INTP_LO: rdat = st_q.prot_lo;
            IDX_INTP_HI: rdat = {st_q.upd_en, st_q.prot_hi};
            IDX_LOW_BOUND: rdat = st_q.low_bound;
            IDX_HIGH_BOUND: rdat = st_q.high_bound;
            IDX_GUARD: rdat = {7'h00, st_q.guard_open};
            IDX_IRQ_STAT: rdat = {6'h00, st_q.irq_stat};
            IDX_IRQ_MASK: rdat = {6'h00, st_q.irq_mask};
            default: rdat = 8'h00;
        endcase
        st_d.apb.prdata = (setup && mapped) ? {24'h0000_00, rdat} : 32'h0000_0000;

        // guard window: opens on the key, shuts after one write to a guarded register or on timeout
        if (st_q.guard_open) begin
            if (st_q.guard_cnt <= GUARD_CNT_W'(1)) begin
                st_d.guard_open = 1'b0;
            end
            st_d.guard_cnt = st_q.guard_cnt - GUARD_CNT_W'(1);
        end

        if (wr && mapped) begin
            if (idx == IDX_GUARD) begin
                st_d.guard_open = (wdat == GUARD_KEY);
                st_d.guard_cnt = (wdat == GUARD_KEY) ? GUARD_CNT_W'(GUARD_WIN_CYC) : '0;
            end else if (idx == IDX_IRQ_STAT) begin
                clr = I_APB.pwdata[1:0];
            end else if (idx == IDX_IRQ_MASK) begin
                st_d.irq_mask = I_APB.pwdata[1:0];
            end else begin
                // unguarded writes to protected registers are dropped silently
                st_d.guard_open = 1'b0;
                st_d.guard_cnt = '0;
                if (st_q.guard_open) begin
                    unique case (idx)
                        IDX_ADDR_TOP: st_d.addr_top = wdat[ADDR_TOP_BIT];
                        IDX_LOW_BOUND: st_d.low_bound = wdat;
                        IDX_HIGH_BOUND: st_d.high_bound = wdat;
                        IDX_INTP_LO: begin
                            if (st_q.upd_en && |wdat) begin
                                st_d.prot_lo = st_q.prot_lo | wdat;
                                st_d.upd_en = 1'b0;
                            end
                        end
                        IDX_INTP_HI: begin
                            if (st_q.upd_en && |wdat[6:0]) begin
                                st_d.prot_hi = st_q.prot_hi | wdat[6:0];
                                st_d.upd_en = 1'b0;
                            end else if (wdat == UPD_EN_VALUE && !locked) begin
                                st_d.upd_en = 1'b1;
                            end
                        end
                        default: st_d.addr_top = st_q.addr_top;
                    endcase
                end
            end
        end

        // commands: one-cycle verdict with the full address
        st_d.cmd.go = I_CMD.valid && !(cmd_guarded && zone_hit);
        st_d.cmd.fail = I_CMD.valid && cmd_guarded && zone_hit;
        st_d.cmd.addr = I_CMD.valid ? cmd_full : st_q.cmd.addr;
        ev[IRQ_CMD_FAIL] = I_CMD.valid && cmd_guarded && zone_hit;

        // reads: protected bytes are replaced, fetches included
        st_d.rd.valid = I_RD.valid;
        st_d.rd.addr = I_RD.addr;
        st_d.rd.data = rd_prot ? 8'h00 : I_RD.data;
        ev[IRQ_RD_ZERO] = I_RD.valid && rd_prot;

        // a new event wins over a clear in the same cycle
        st_d.irq_stat = (st_q.irq_stat & ~clr) | ev;
        st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
    end

    // every reset source arrives on I_RESET
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign O_APB = st_q.apb;
    assign O_CMD = st_q.cmd;
    assign O_RD = st_q.rd;
    assign O_IRQ = st_q.irq;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);

    AST_ADDR_TOP: assert property (I_CMD.valid |=> O_CMD.addr[16] == $past(st_q.addr_top))
        else $error("command address bit 16 not from top register");
    AST_BLOCKED: assert property (I_CMD.valid && cmd_guarded && zone_hit |=> O_CMD.fail && !O_CMD.go)
        else $error("protected command not failed");
    AST_LOW_ZONE: assert property (I_CMD.valid && I_CMD.kind == FCP_CMD_ERASE &&
        cmd_full[16:9] < st_q.low_bound |=> O_CMD.fail)
        else $error("low zone erase not blocked");
    AST_HIGH_ZONE: assert property (I_CMD.valid && I_CMD.kind == FCP_CMD_WRITE &&
        cmd_full[16:9] > st_q.high_bound |=> O_CMD.fail)
        else $error("high zone write not blocked");
    AST_READ_PASS: assert property (I_CMD.valid && I_CMD.kind == FCP_CMD_READ |=> O_CMD.go && !O_CMD.fail)
        else $error("read command checked against zones");
    AST_ZERO_READ: assert property (I_RD.valid && rd_prot |=> O_RD.valid && O_RD.data == 8'h00)
        else $error("protected read returned data");
    AST_SET_ONLY: assert property ((range_bits & $past(range_bits)) == $past(range_bits))
        else $error("internal protection bit cleared without reset");
    AST_LOCKED: assert property (|range_bits |-> !st_q.upd_en)
        else $error("update enable set after range programmed");
    AST_NO_EN: assert property (wr && idx == IDX_INTP_LO && !st_q.upd_en |=> $stable(st_q.prot_lo))
        else $error("range accepted without update enable");
    AST_GUARD: assert property (wr && idx == IDX_LOW_BOUND && !st_q.guard_open |=> $stable(st_q.low_bound))
        else $error("guarded register written without guard");
    AST_PRIO: assert property (I_RD.valid && range_bits[0] && I_RD.addr[16:13] != 4'h0
        |=> O_RD.data == 8'h00)
        else $error("lowest range bit did not cover its region");

    COV_BLOCK: cover property (I_CMD.valid && cmd_guarded && zone_hit ##1 O_CMD.fail);
    COV_PASS: cover property (I_CMD.valid && I_CMD.kind == FCP_CMD_WRITE && !zone_hit ##1 O_CMD.go);
    COV_LOCK: cover property (st_q.upd_en ##1 |range_bits);
    COV_ZERO: cover property (I_RD.valid && rd_prot ##1 O_IRQ);
endmodule

// File: fcp_cpu_model.sv
`timescale 1ns/1ps
module fcp_cpu_model (
    // clock
    input wire logic i_clk,
    // design answers
    input wire fcp_pkg::fcp_cmd_rsp_s i_cmd,
    input wire fcp_pkg::fcp_rd_s i_rd,
    // requests
    output fcp_pkg::fcp_cmd_req_s o_cmd,
    output fcp_pkg::fcp_rd_s o_rd
);
    import fcp_pkg::*;
    initial begin
        o_cmd = '0;
        o_rd = '0;
    end
    task automatic cmd(input logic [1:0] k, input logic [15:0] a, output fcp_cmd_rsp_s r);
        @(posedge i_clk);
        o_cmd <= '{1'b1, fcp_cmd_e'(k), a};
        @(posedge i_clk);
        o_cmd.valid <= 1'b0;
        @(negedge i_clk);
        r = i_cmd;
    endtask
    // fetched bytes are only compared, never run as code
    task automatic rd(input logic [16:0] a, input logic [7:0] d, output fcp_rd_s r);
        @(posedge i_clk);
        o_rd <= '{1'b1, a, d};
        @(posedge i_clk);
        // released lines flip so a stale byte cannot pass
        o_rd <= '{1'b0, ~a, ~d};
        @(negedge i_clk);
        r = i_rd;
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    import fcp_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    fcp_apb_req_s apb_req = '0;
    fcp_apb_rsp_s apb_rsp;
    fcp_cmd_req_s cmd;
    fcp_cmd_rsp_s cmd_rsp;
    fcp_rd_s rd_req;
    fcp_rd_s rd_rsp;
    logic o_irq;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'd90235;
    int lowb, highb, top, intp, upd, stat, mask;
    always #(CLK_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;
    fcp_top fcp_top_inst (.I_SYS_CLK(i_sys_clk), .I_RESET(i_reset), .I_APB(apb_req), .O_APB(apb_rsp),
        .I_CMD(cmd), .O_CMD(cmd_rsp), .I_RD(rd_req), .O_RD(rd_rsp), .O_IRQ(o_irq));
    fcp_cpu_model fcp_cpu_model_inst (.i_clk(i_sys_clk), .i_cmd(cmd_rsp), .i_rd(rd_rsp), .o_cmd(cmd),
        .o_rd(rd_req));
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d, output logic [32:0] r);
        int n;
        @(posedge i_sys_clk);
        apb_req <= '{1'b1, 1'b0, w, {idx, 2'b00}, d};
        @(posedge i_sys_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        // a slave that never answers counts as a mismatch
        if (n >= 50) begin
            errors++;
            $display("unexpected pready: expected 1, seen %b", apb_rsp.pready);
        end
        r = {apb_rsp.pslverr, apb_rsp.prdata};
        apb_req <= '0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [32:0] r;
        xfer(1'b1, idx, {24'h00_0000, d}, r);
    endtask
    task automatic gwr(input logic [15:0] idx, input logic [7:0] d);
        wr(IDX_GUARD, GUARD_KEY);
        wr(idx, d);
    endtask
    task automatic rdchk(input string n, input logic [15:0] idx, input logic [32:0] e);
        logic [32:0] r;
        xfer(1'b0, idx, '0, r);
        chk(n, e, r);
    endtask
    task automatic regs();
        rdchk("top", IDX_ADDR_TOP, top);
        rdchk("low", IDX_LOW_BOUND, lowb);
        rdchk("high", IDX_HIGH_BOUND, highb);
        rdchk("intp_lo", IDX_INTP_LO, intp & 255);
        rdchk("intp_hi", IDX_INTP_HI, upd * 128 + (intp >> 8));
        rdchk("stat", IDX_IRQ_STAT, stat);
        rdchk("mask", IDX_IRQ_MASK, mask);
    endtask
    task automatic cmdchk(input int k, input logic [15:0] a);
        fcp_cmd_rsp_s r;
        int u;
        logic f;
        u = {top[0], a} >> 9;
        f = (k == 1 || k == 2) && (u < lowb || u > highb);
        if (f) stat |= 1;
        fcp_cpu_model_inst.cmd(k[1:0], a, r);
        chk("cmd", {!f, f, top[0], a}, r);
    endtask
    task automatic rdchk2(input logic [16:0] a);
        fcp_rd_s r;
        logic [7:0] d;
        logic z;
        d = 8'(lfsr()) | 8'h01;
        z = 1'b0;
        for (int k = 0; k < 15; k++) if (intp[k] && a >= (k + 1) * 32'h0000_2000) z = 1'b1;
        if (z) stat |= 2;
        fcp_cpu_model_inst.rd(a, d, r);
        chk("read", {1'b1, a, z ? 8'h00 : d}, r);
    endtask
    task automatic do_reset();
        i_reset <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        {lowb, highb, top, intp, upd, stat, mask} = {32'd255, 192'd0};
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge i_sys_clk);
        errors++;
        summarize();
    end
    initial begin
        do_reset();
        regs();
        rdchk("unmapped", 16'hA040, 33'h1_0000_0000);
        for (int k = 0; k < 4; k++) cmdchk(k, 16'(lfsr()));
        wr(IDX_LOW_BOUND, 8'h10);
        regs();
        $display("test reset done");
        lowb = 1 + lfsr() % 127;
        highb = 128 + lfsr() % 127;
        gwr(IDX_LOW_BOUND, 8'(lowb));
        gwr(IDX_HIGH_BOUND, 8'(highb));
        for (int i = 0; i < 32; i++) begin
            if (i % 16 == 0) begin
                top = i / 16;
                gwr(IDX_ADDR_TOP, top ? 8'hFF : 8'h00);
                regs();
                cmdchk(1, 16'((top ? highb : lowb - 1) * 512 + 511));
                cmdchk(2, 16'((top ? highb + 1 : lowb) * 512));
            end
            cmdchk(lfsr() % 4, 16'(lfsr()));
        end
        $display("test zones done");
        gwr(IDX_INTP_LO, 8'h01);
        regs();
        gwr(IDX_INTP_HI, UPD_EN_VALUE);
        upd = 1;
        regs();
        gwr(IDX_INTP_LO, 8'h14);
        {upd, intp} = {32'd0, 32'h0000_0014};
        gwr(IDX_INTP_HI, UPD_EN_VALUE);
        gwr(IDX_INTP_LO, 8'h00);
        gwr(IDX_INTP_HI, 8'h01);
        regs();
        for (int i = 0; i < 24; i++) rdchk2(17'(i < 2 ? 32'h0000_5FFF + i : lfsr()));
        $display("test internal done");
        wr(IDX_IRQ_STAT, 8'h03);
        stat = 0;
        wr(IDX_IRQ_MASK, 8'h01);
        mask = 1;
        rdchk2(17'h1_FFFF);
        repeat (2) @(negedge i_sys_clk);
        chk("irq", 0, o_irq);
        cmdchk(2, 16'hFFFF);
        repeat (2) @(negedge i_sys_clk);
        chk("irq", 1, o_irq);
        wr(IDX_IRQ_STAT, 8'h01);
        stat = 2;
        regs();
        chk("irq", 0, o_irq);
        $display("test irq done");
        do_reset();
        regs();
        rdchk2(17'h1_FFFF);
        $display("test second reset done");
        summarize();
    end
endmodule
